/* spi_status_pkg.sv */
package spi_status_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned T_WRITE_MS       = 4;
  // Longest self-timed write, rounded down to whole cycles
  localparam int unsigned WRITE_CYCLES_DEF = T_WRITE_MS * 1000 * CLK_MHZ;

  // ----------------------------------------------------------------
  // Opcodes, bit 3 ignored
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_MASK       = 8'hF7;
  localparam logic [7:0] OP_SET_LATCH  = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH  = 8'h04;
  localparam logic [7:0] OP_STATUS_RD  = 8'h05;
  localparam logic [7:0] OP_STATUS_WR  = 8'h01;
  localparam logic [7:0] OP_ARRAY_WR   = 8'h02;
  localparam logic [7:0] OP_NONE       = 8'hFF;

  // ----------------------------------------------------------------
  // Status register layout
  // ----------------------------------------------------------------
  localparam int unsigned BIT_BUSY     = 0;
  localparam int unsigned BIT_WEL      = 1;
  localparam int unsigned BIT_LOCK_LO  = 2;
  localparam int unsigned BIT_LOCK_HI  = 3;
  localparam int unsigned BIT_ARM      = 7;
  localparam logic [7:0]  STATUS_BUSY_VIEW = 8'hFF;
  localparam logic [1:0]  LOCK_RESET   = 2'h0;
  localparam logic        ARM_RESET    = 1'b0;
  localparam logic        WEL_RESET    = 1'b0;

  // ----------------------------------------------------------------
  // Frame bit counts
  // ----------------------------------------------------------------
  localparam logic [7:0] CNT_OP_END    = 8'h08;
  localparam logic [7:0] CNT_STATUS_WRITE_CMD_END  = 8'h10;
  localparam logic [7:0] CNT_ADDR_LAST = 8'h17;
  localparam logic [7:0] CNT_WR_MIN    = 8'h20;
  localparam logic [7:0] CNT_WRAP_FROM = 8'hFF;
  localparam logic [7:0] CNT_WRAP_TO   = 8'hF8;

  // ----------------------------------------------------------------
  // Locked regions and pin sync reset {cs_n, sck, si, hold_n, wp_n}
  // ----------------------------------------------------------------
  localparam logic [11:0] LOCK_QTR_BASE  = 12'hC00;
  localparam logic [11:0] LOCK_HALF_BASE = 12'h800;
  localparam logic [4:0]  PIN_SYNC_RST   = 5'h13;

  typedef enum logic [1:0] {WE_IDLE, WE_STATUS, WE_ARRAY} write_kind_t;

  function automatic logic is_cmd(input logic [7:0] op, input logic [7:0] code);
    return (op & OP_MASK) == code;
  endfunction

endpackage

/* prot_if.sv */
`timescale 1ns/1ps
interface prot_if;
  logic [1:0]  lock;
  logic        arm;
  logic        wp_n;
  logic        wel;
  logic [11:0] addr;
  logic        hw_protect;
  logic        addr_locked;
  logic        status_wr_ok;
  logic        array_wr_ok;

  modport ctrl (output lock, arm, wp_n, wel, addr,
                input  hw_protect, addr_locked, status_wr_ok, array_wr_ok);
  modport chk  (input  lock, arm, wp_n, wel, addr,
                output hw_protect, addr_locked, status_wr_ok, array_wr_ok);
endinterface

/* pin_sync.sv */
`timescale 1ns/1ps
module pin_sync
  import spi_status_pkg::*;
#(
  parameter int unsigned WIDTH   = 5,
  parameter logic [4:0]  RST_VAL = PIN_SYNC_RST
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        meta[i] <= RST_VAL[i];
        q[i]    <= RST_VAL[i];
      end else begin
        meta[i] <= d[i];
        q[i]    <= meta[i];
      end
    end
  end
endmodule // pin_sync

/* protect_check.sv */
`timescale 1ns/1ps
module protect_check
  import spi_status_pkg::*;
(
  prot_if.chk pi
);
  function automatic logic region_hit(input logic [1:0] sel, input logic [11:0] a);
    case (sel)
      2'h1:    return a >= LOCK_QTR_BASE;
      2'h2:    return a >= LOCK_HALF_BASE;
      2'h3:    return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  always_comb begin
    pi.hw_protect   = !pi.wp_n && pi.arm;
    pi.addr_locked  = region_hit(pi.lock, pi.addr);
    pi.status_wr_ok = pi.wel && !pi.hw_protect;
    // Pin and arm bit never gate the array
    pi.array_wr_ok  = pi.wel && !pi.addr_locked;
  end
endmodule // protect_check

/* spi_eeprom_status_protect.sv */
`timescale 1ns/1ps
// Function
// - Select rising ends the operation or starts the internal write.
// - Deselected: standby unless writing; SO stays high impedance.
// - Modes 0 and 3: sample SI on SCK rise, change SO on fall.
// - Suspend input low freezes serial state and ignores SI, SCK, SO.
// - Status register is read-only if hardware protected or latch clear.
// - Bit 0 shows busy; while busy only status read is accepted.
// - Bit 1 is the write latch; when clear nothing may change.
// - Latch clears at power-up, set only by set-latch instruction.
// - Bits 2,3 are region-lock selectors, non-volatile, zero from factory; here arst_n loads them with 00.
// - Locked region is never written, whatever the other settings.
// - Selectors 00 none, 01 C00-FFF, 10 800-FFF, 11 000-FFF.
// - Bits 4 to 6 are not kept; read 0 except while writing.
// - Hardware protection active only with pin low and arm bit set.
// - Hardware protection blocks selectors and arm bit, not the array.
// - Arm bit cannot go from 1 to 0 while the pin is low.
// - During the internal write every status bit reads 1.
// - Opcodes: set 0000X110, clear 0000X100, read 0000X101, write 0000X001.
// - Clear-latch, status-write and array-write clear the latch.
// - Status write stores only selectors and arm bit.
module spi_eeprom_status_protect
  import spi_status_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = WRITE_CYCLES_DEF
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        cs_n,
  input  wire logic        sck,
  input  wire logic        si,
  input  wire logic        hold_n,
  input  wire logic        wp_n,
  output logic             so,
  output logic             so_oe_n,
  output logic             standby,
  output logic             busy,
  output logic             array_wr_start,
  output logic [11:0]      array_wr_addr
);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [4:0] pins_s;
  logic       cs_s, sck_s, si_s, hold_s, wp_s;
  logic       sck_d, cs_d;
  logic       sck_rise, sck_fall, cs_rise, live;

  pin_sync #(.WIDTH(5), .RST_VAL(PIN_SYNC_RST)) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({cs_n, sck, si, hold_n, wp_n}),
    .q      (pins_s)
  );

  assign {cs_s, sck_s, si_s, hold_s, wp_s} = pins_s;
  assign sck_rise = sck_s && !sck_d;
  assign sck_fall = !sck_s && sck_d;
  assign cs_rise  = cs_s && !cs_d;
  assign live     = !cs_s && hold_s;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  cnt, next_cnt;
  logic [15:0] sh, next_sh;
  logic [7:0]  opcode, next_opcode;
  logic [7:0]  wsr_data, next_wsr_data;
  logic [11:0] addr, next_addr;
  logic        wel, next_wel;
  logic [1:0]  lock, next_lock;
  logic        arm, next_arm;
  logic [1:0]  pend_lock, next_pend_lock;
  logic        pend_arm, next_pend_arm;
  write_kind_t wk, next_wk;
  logic [31:0] timer, next_timer;
  logic        next_so, next_so_oe_n, next_standby, next_busy;
  logic        next_array_wr_start;
  logic [11:0] next_array_wr_addr;
  logic [7:0]  status_view;
  logic        rd_phase;

  prot_if pi ();
  assign pi.lock = lock;
  assign pi.arm  = arm;
  assign pi.wp_n = wp_s;
  assign pi.wel  = wel;
  assign pi.addr = addr;

  protect_check u_prot (.pi(pi));

  always_comb begin
    status_view = {arm, 3'b000, lock, wel, 1'b0};
    if (wk != WE_IDLE) begin
      status_view = STATUS_BUSY_VIEW;
    end
  end

  assign rd_phase = !cs_s && is_cmd(opcode, OP_STATUS_RD) && (cnt >= CNT_OP_END);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_cnt            = cnt;
    next_sh             = sh;
    next_opcode         = opcode;
    next_wsr_data       = wsr_data;
    next_addr           = addr;
    next_wel            = wel;
    next_lock           = lock;
    next_arm            = arm;
    next_pend_lock      = pend_lock;
    next_pend_arm       = pend_arm;
    next_wk             = wk;
    next_timer          = timer;
    next_so             = so;
    next_so_oe_n        = so_oe_n;
    next_array_wr_start = 1'b0;
    next_array_wr_addr  = array_wr_addr;

    // Frame decode; counter restarts on every select
    if (cs_s) begin
      next_cnt    = 8'h00;
      next_opcode = OP_NONE;
    end else if (live && sck_rise) begin
      next_sh  = {sh[14:0], si_s};
      // Wrap keeps byte alignment on very long frames
      next_cnt = (cnt == CNT_WRAP_FROM) ? CNT_WRAP_TO : cnt + 8'h01;
      if (cnt == CNT_OP_END - 8'h01) begin
        next_opcode = {sh[6:0], si_s};
      end
      if (cnt == CNT_STATUS_WRITE_CMD_END - 8'h01) begin
        next_wsr_data = {sh[6:0], si_s};
      end
      if (cnt == CNT_ADDR_LAST) begin
        next_addr = {sh[10:0], si_s};
      end
    end

    // Serial out: idles released, resumes after suspend
    if (!rd_phase || !hold_s) begin
      next_so_oe_n = 1'b1;
    end else if (sck_fall) begin
      next_so      = status_view[~cnt[2:0]];
      next_so_oe_n = 1'b0;
    end else if (cnt > CNT_OP_END) begin
      next_so_oe_n = 1'b0;
    end

    // Instructions act on select release; busy accepts only a status read
    if (cs_rise && wk == WE_IDLE) begin
      if (cnt == CNT_OP_END && is_cmd(opcode, OP_SET_LATCH)) begin
        next_wel = 1'b1;
      end
      if (cnt == CNT_OP_END && is_cmd(opcode, OP_CLR_LATCH)) begin
        next_wel = 1'b0;
      end
      if (cnt == CNT_STATUS_WRITE_CMD_END && is_cmd(opcode, OP_STATUS_WR)
          && pi.status_wr_ok) begin
        next_pend_lock = {wsr_data[BIT_LOCK_HI], wsr_data[BIT_LOCK_LO]};
        next_pend_arm  = wsr_data[BIT_ARM];
        next_wk        = WE_STATUS;
        next_timer     = 32'h0000_0000;
        next_wel       = 1'b0;
      end
      if (cnt >= CNT_WR_MIN && cnt[2:0] == 3'h0 && is_cmd(opcode, OP_ARRAY_WR)
          && pi.array_wr_ok) begin
        next_wk             = WE_ARRAY;
        next_timer          = 32'h0000_0000;
        next_wel            = 1'b0;
        next_array_wr_start = 1'b1;
        next_array_wr_addr  = addr;
      end
    end

    // Self-timed write; status values change only at its end
    case (wk)
      WE_IDLE: begin
      end
      WE_STATUS, WE_ARRAY: begin
        next_timer = timer + 32'h0000_0001;
        if (timer == WRITE_CYCLES - 1) begin
          next_wk = WE_IDLE;
          if (wk == WE_STATUS) begin
            next_lock = pend_lock;
            next_arm  = pend_arm;
          end
        end
      end
      default: begin
        next_wk = WE_IDLE;
      end
    endcase

    next_standby = cs_s && (next_wk == WE_IDLE);
    next_busy    = next_wk != WE_IDLE;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_d          <= 1'b0;
      cs_d           <= 1'b1;
      cnt            <= 8'h00;
      sh             <= 16'h0000;
      opcode         <= OP_NONE;
      wsr_data       <= 8'h00;
      addr           <= 12'h000;
      wel            <= WEL_RESET;
      lock           <= LOCK_RESET;
      arm            <= ARM_RESET;
      pend_lock      <= LOCK_RESET;
      pend_arm       <= ARM_RESET;
      wk             <= WE_IDLE;
      timer          <= 32'h0000_0000;
      so             <= 1'b0;
      so_oe_n        <= 1'b1;
      standby        <= 1'b1;
      busy           <= 1'b0;
      array_wr_start <= 1'b0;
      array_wr_addr  <= 12'h000;
    end else begin
      sck_d          <= sck_s;
      cs_d           <= cs_s;
      cnt            <= next_cnt;
      sh             <= next_sh;
      opcode         <= next_opcode;
      wsr_data       <= next_wsr_data;
      addr           <= next_addr;
      wel            <= next_wel;
      lock           <= next_lock;
      arm            <= next_arm;
      pend_lock      <= next_pend_lock;
      pend_arm       <= next_pend_arm;
      wk             <= next_wk;
      timer          <= next_timer;
      so             <= next_so;
      so_oe_n        <= next_so_oe_n;
      standby        <= next_standby;
      busy           <= next_busy;
      array_wr_start <= next_array_wr_start;
      array_wr_addr  <= next_array_wr_addr;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_SO_HIZ_DESELECTED: assert property (cs_s && cs_d |-> so_oe_n)
    else $error("SO driven while deselected");
  AST_HOLD_FREEZES: assert property (!hold_s && !cs_s |=> $stable(cnt) && $stable(sh))
    else $error("Serial state moved during suspend");
  AST_BUSY_REJECTS: assert property (wk != WE_IDLE && cs_rise |=> $stable(wel))
    else $error("Instruction accepted while busy");
  AST_WEL_SET_SOURCE: assert property ($rose(wel)
    |-> $past(cs_rise && cnt == CNT_OP_END && is_cmd(opcode, OP_SET_LATCH)))
    else $error("Write latch set without set-latch instruction");
  AST_STATUS_REFUSED: assert property (cs_rise && wk == WE_IDLE && cnt == CNT_STATUS_WRITE_CMD_END
    && is_cmd(opcode, OP_STATUS_WR) && (pi.hw_protect || !wel) |=> wk == WE_IDLE)
    else $error("Status write accepted while read-only");
  AST_STATUS_AT_END: assert property ($changed(lock) || $changed(arm)
    |-> $past(wk == WE_STATUS && timer == WRITE_CYCLES - 1))
    else $error("Status bits changed outside a status write");
  AST_LOCKED_REGION: assert property (array_wr_start |-> !$past(pi.addr_locked))
    else $error("Array write started in locked region");
  // Pin and arm bit must never stop an array write
  AST_HW_ARRAY_FREE: assert property (cs_rise && wk == WE_IDLE && wel
    && is_cmd(opcode, OP_ARRAY_WR) && cnt >= CNT_WR_MIN && cnt[2:0] == 3'h0
    && !pi.addr_locked |=> array_wr_start)
    else $error("Write-protect pin gated an array write");
  AST_LATCH_CLEARED: assert property ($rose(wk != WE_IDLE) |-> !wel)
    else $error("Write latch still set after accepted write");
  // A new write may be accepted right after the old one ends
  AST_WRITE_ENDS: assert property (wk != WE_IDLE && timer == WRITE_CYCLES - 1
    |=> wk == WE_IDLE && !busy ##1 (!busy || $past(cs_rise)))
    else $error("Internal write did not end on time");
  AST_STANDBY: assert property (cs_s && cs_d && wk == WE_IDLE |=> standby)
    else $error("Not in standby while deselected and idle");
  AST_SO_ONLY_READ: assert property (!so_oe_n |-> $past(rd_phase))
    else $error("SO driven outside a status read");
  AST_SPARE_ZERO: assert property (sck_fall && rd_phase && hold_s && wk == WE_IDLE
    && cnt[2:0] inside {3'h1, 3'h2, 3'h3} |=> !so)
    else $error("Spare status bits not zero when idle");
  AST_BUSY_ALL_ONES: assert property (busy && rd_phase && hold_s && sck_fall |=> so)
    else $error("Status bit read 0 during internal write");

  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  COV_STATUS_READ: cover property (!so_oe_n ##1 so_oe_n);
  COV_STATUS_WRITE: cover property ($rose(wk == WE_STATUS));
  COV_ARRAY_WRITE: cover property (array_wr_start);
  COV_HOLD_MID_FRAME: cover property (!cs_s && cnt > 8'h00 && !hold_s);

endmodule // spi_eeprom_status_protect

/* spi_master_model.sv */
`timescale 1ns/1ps
module spi_master_model (
  input  wire logic clk,
  input  wire logic so,
  input  wire logic so_oe_n,
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  output logic      hold_n
);
  initial begin
    cs_n   = 1'b1;
    sck    = 1'b0;
    si     = 1'b0;
    hold_n = 1'b1;
  end

  task automatic half();
    repeat (4) @(negedge clk);
  endtask

  // ----------------------------------------------------------------
  // One framed transfer, MSB first
  // ----------------------------------------------------------------
  // Undriven SO is taken as unknown so a silent device never matches
  task automatic frame(input int n, input logic [39:0] d, input logic mode3,
                       input int hold_at, output logic [39:0] rx);
    rx = '0;
    sck <= mode3;
    half();
    cs_n <= 1'b0;
    half();
    for (int i = n - 1; i >= 0; i--) begin
      sck <= 1'b0;
      si  <= d[i];
      half();
      if (i == hold_at) begin
        hold_n <= 1'b0;
        half();
        repeat (2) begin
          sck <= 1'b1;
          si  <= ~si;
          half();
          sck <= 1'b0;
          half();
        end
        hold_n <= 1'b1;
        half();
      end
      sck <= 1'b1;
      half();
      rx = {rx[38:0], so_oe_n ? 1'bx : so};
    end
    if (!mode3) begin
      sck <= 1'b0;
      half();
    end
    cs_n <= 1'b1;
    si   <= ~si;
    half();
    half();
  endtask
endmodule // spi_master_model

/* spi_eeprom_status_protect_test.sv */
`timescale 1ns/1ps
module spi_eeprom_status_protect_test;
  import spi_status_pkg::*;
  localparam int unsigned WC = 400;
  logic        clk, arst_n, cs_n, sck, si, hold_n, wp_n;
  logic        so, so_oe_n, standby, busy, array_wr_start;
  logic [11:0] array_wr_addr, last_addr;
  logic [39:0] rx;
  logic [7:0]  st;
  int          num_errors = 0;
  int          tests_run = 0;
  int          starts = 0;

  spi_eeprom_status_protect #(.WRITE_CYCLES(WC)) u_spi_eeprom_status_protect (
    .clk(clk), .arst_n(arst_n), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
    .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n), .standby(standby), .busy(busy),
    .array_wr_start(array_wr_start), .array_wr_addr(array_wr_addr));
  spi_master_model u_spi_master_model (.clk(clk), .so(so), .so_oe_n(so_oe_n),
    .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (array_wr_start === 1'b1) begin
      starts    <= starts + 1;
      last_addr <= array_wr_addr;
    end
  end

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (num_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic rd(input logic mode3, input int hold_at);
    u_spi_master_model.frame(16, 40'h0000000500, mode3, hold_at, rx);
    st = rx[7:0];
  endtask

  task automatic cmd(input logic [7:0] op);
    u_spi_master_model.frame(8, {32'h0, op}, 1'b0, -1, rx);
  endtask

  task automatic status_write_cmd(input logic [7:0] d);
    u_spi_master_model.frame(16, {24'h0, 8'h01, d}, 1'b0, -1, rx);
  endtask

  // Bounded wait on busy, then a throw-away status read
  task automatic settle();
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge clk);
    check({11'h0, busy}, 12'h0);
    repeat (4) @(negedge clk);
    rd(1'b0, -1);
  endtask

  task automatic arr(input logic [11:0] a, input logic ok);
    int n0;
    n0 = starts;
    u_spi_master_model.frame(32, {8'h0, 8'h02, 4'h0, a, 8'hA5}, 1'b0, -1, rx);
    check(12'(starts - n0), {11'h0, ok});
    if (ok) check(last_addr, a);
    settle();
  endtask

  task automatic lock_case(input logic [7:0] s, input logic [11:0] a, input logic ok);
    cmd(8'h06);
    status_write_cmd(s);
    settle();
    cmd(8'h06);
    arr(a, ok);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check({11'h0, standby}, 12'h1);
    check({11'h0, so_oe_n}, 12'h1);
    rd(1'b0, -1);
    check({4'h0, st}, 12'h000);
  endtask

  task automatic t_latch();
    cmd(8'h0E);
    rd(1'b0, -1);
    check({4'h0, st}, 12'h002);
    cmd(8'h0C);
    rd(1'b0, -1);
    check({4'h0, st}, 12'h000);
    status_write_cmd(8'h8C);
    rd(1'b0, -1);
    check({4'h0, st}, 12'h000);
  endtask

  task automatic t_status_write_cmd();
    cmd(8'h06);
    status_write_cmd(8'hF7);
    check({11'h0, busy}, 12'h1);
    check({11'h0, standby}, 12'h0);
    rd(1'b0, -1);
    check({4'h0, st}, 12'h0FF);
    cmd(8'h06);
    settle();
    check({11'h0, standby}, 12'h1);
    rd(1'b0, -1);
    check({4'h0, st}, 12'h084);
  endtask

  task automatic t_hwprot();
    wp_n = 1'b0;
    cmd(8'h06);
    status_write_cmd(8'h00);
    settle();
    rd(1'b0, -1);
    check({4'h0, st & 8'hFC}, 12'h084);
    cmd(8'h06);
    arr(12'h100, 1'b1);
    cmd(8'h06);
    arr(12'hC00, 1'b0);
    cmd(8'h06);
    arr(12'hBFF, 1'b1);
    wp_n = 1'b1;
  endtask

  task automatic t_regions();
    lock_case(8'h08, 12'h7FF, 1'b1);
    lock_case(8'h08, 12'h800, 1'b0);
    lock_case(8'h0C, 12'h000, 1'b0);
    lock_case(8'h04, 12'hBFF, 1'b1);
    lock_case(8'h04, 12'hC00, 1'b0);
    lock_case(8'h00, 12'hFFF, 1'b1);
    arr(12'h000, 1'b0);
  endtask

  task automatic t_link();
    cmd(8'h06);
    rd(1'b0, 3);
    check({4'h0, st}, 12'h002);
    rd(1'b1, -1);
    check({4'h0, st}, 12'h002);
    check({11'h0, so_oe_n}, 12'h1);
    // Mid-run reset must drop the latch again
    cmd(8'h06);
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    rd(1'b0, -1);
    check({4'h0, st}, 12'h000);
    // Fixed wait instead of polling busy
    cmd(8'h06);
    status_write_cmd(8'h08);
    repeat (WC + 20) @(negedge clk);
    rd(1'b0, -1);
    check({4'h0, st}, 12'h008);
  endtask

  initial begin
    arst_n = 1'b0;
    wp_n   = 1'b1;
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_latch();
    t_status_write_cmd();
    t_hwprot();
    t_regions();
    t_link();
    results();
  end

  // Whole run needs well under half of this span
  initial begin
    #400000;
    num_errors++;
    results();
  end
endmodule // spi_eeprom_status_protect_test
